/* File: design/tocc_params.svh */
// Constants, register offsets and field positions of the one-shot/continuous/counter timer.
// Contract
// [RULE_01] One-shot: count equals reload gives output pulse, interrupt, count back to 0001H.
// [RULE_02] One-shot output pulse lasts one timer clock with polarity from polarity bit; the code holds it until the next prescaled tick.
// [RULE_03] After one-shot expiry the timer idles until the next trigger edge.
// [RULE_04] One-shot counts prescaled timer clocks from start value up to reload.
// [RULE_05] Continuous mode counts prescaled timer clocks; period is reload times prescale.
// [RULE_06] Continuous first period runs from start value; later periods start at 0001H.
// [RULE_07] Counter mode increments on external input transitions, not timer clock.
// [RULE_08] Counter mode polarity bit selects rising or falling input edge.
// [RULE_09] Counter mode bypasses the prescaler; every qualifying edge counts.
// [RULE_10] External input toggles no faster than a quarter of the timer clock.
// [RULE_11] Counter mode reload raises interrupt, sets count to 0001H, keeps counting.
// [RULE_12] Counter mode with output enabled inverts the output at each reload.
// [RULE_13] Disable timer before choosing counter mode; edge select presets output level.
// [RULE_14] Software picks the timer clock source through the second control register.
// [RULE_15] Mode field value 1011B selects triggered one-shot operation.
// [RULE_16] Interrupt condition field 11B limits interrupts to reload events only.
// [RULE_17] Prescale field 000B divides by one.
// [RULE_18] Clock-origin bit 1 clocks the timer from the 32kHz peripheral clock tick.
// [RULE_19] Polarity 0 in one-shot triggers on rising edges, idle output is 0.
// [RULE_20] Count and reload are 16 bits of high and low byte; reload on equality.
`ifndef TOCC_PARAMS_SVH
`define TOCC_PARAMS_SVH
`define TOCC_OFS_CTRL0     4'h0
`define TOCC_OFS_CTRL1     4'h4
`define TOCC_OFS_CNT_HI    4'h8
`define TOCC_OFS_CNT_LO    4'hC
`define TOCC_OFS_RLD_HI    5'h10
`define TOCC_OFS_RLD_LO    5'h14
`define TOCC_OFS_STATUS    5'h18
`define TOCC_MODE_CONT     4'h1
`define TOCC_MODE_COUNTER  4'h3
`define TOCC_MODE_ONESHOT  4'hB
`define TOCC_IRQ_RELOAD    2'h3
`define TOCC_CNT_START     16'h0001
`define TOCC_RLD_RESET     16'hFFFF
`define TOCC_CTRL0_RESET   8'h00
`define TOCC_CTRL1_RESET   8'h00
`define TOCC_B_EN          7
`define TOCC_B_POL         6
`define TOCC_B_OUTEN       5
`define TOCC_B_ORIGIN      3
`endif

/* File: design/tocc_pkg.sv */
// Types shared by the timer block.
package tocc_pkg;
  typedef enum logic [2:0] {
    TOCC_IDLE = 3'b001,
    TOCC_RUN  = 3'b010,
    TOCC_FREE = 3'b100
  } tocc_state_t;
endpackage : tocc_pkg

/* File: design/tocc_prescaler.sv */
// Prescaler that turns a timer clock tick into a divided count tick.
module tocc_prescaler
  import tocc_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst,
  // Control.
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  input  wire logic       tick_in,
  // Divided tick.
  output logic            tick_out
);
  logic [6:0] cnt_q;
  logic [6:0] last;

  // Divide by two to the power of the select value, 000B divides by one.
  assign last = 7'((8'h01 << div_sel) - 8'h01);

  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_q <= 7'h00;
    end else if (tick_in) begin
      cnt_q <= (cnt_q >= last) ? 7'h00 : cnt_q + 7'h01;
    end
  end

  assign tick_out = run && tick_in && (cnt_q >= last); // see [RULE_17]
endmodule : tocc_prescaler

/* File: design/tocc_timer.sv */
// Top of the 16-bit one-shot, continuous and counter-mode timer with an Avalon-MM slave.
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`include "tocc_params.svh"
module tocc_timer
  import tocc_pkg::*;
#(
  parameter int unsigned SLOW_DIV = 625
)
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave.
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Timer pins.
  input  wire logic        tmr_in,
  output logic             tmr_out,
  output logic             tmr_irq
);
  logic [7:0]  ctrl0_q;
  logic [7:0]  ctrl1_q;
  logic [15:0] cnt_q;
  logic [15:0] rld_q;
  logic        out_q;
  logic        irq_q;
  logic        pend_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        in_q;
  logic [15:0] slow_q;
  tocc_state_t state_q;

  logic [3:0] timer_mode_field;
  logic [1:0] irq_condition_select;
  logic [2:0] clock_divider_select;
  logic       clock_origin_select;
  logic       edge_and_level_select;
  logic       run_en;
  logic       out_en;
  logic       slow_tick;
  logic       tclk_tick;
  logic       clock_divider_select_tick;
  logic       in_edge;
  logic       step;
  logic       hit;
  logic       req;
  logic       wr_acc;
  logic       rd_acc;
  logic       mode_cnt;
  logic       mode_one;
  logic       mode_cont;

  assign timer_mode_field      = ctrl0_q[3:0]; // see [RULE_15]
  assign irq_condition_select  = ctrl0_q[5:4];
  assign clock_divider_select  = ctrl1_q[2:0];
  assign clock_origin_select   = ctrl1_q[`TOCC_B_ORIGIN];
  assign edge_and_level_select = ctrl1_q[`TOCC_B_POL];
  assign run_en                = ctrl1_q[`TOCC_B_EN];
  assign out_en                = ctrl1_q[`TOCC_B_OUTEN];
  assign mode_one  = (timer_mode_field == `TOCC_MODE_ONESHOT); // see [RULE_15]
  assign mode_cnt  = (timer_mode_field == `TOCC_MODE_COUNTER);
  assign mode_cont = !mode_one && !mode_cnt;

  // Slow clock tick standing in for the 32kHz peripheral clock.
  always_ff @(posedge mclk) begin
    if (rst || slow_q == 16'(SLOW_DIV - 1)) begin
      slow_q <= 16'h0000;
    end else begin
      slow_q <= slow_q + 16'h0001;
    end
  end
  assign slow_tick = (slow_q == 16'(SLOW_DIV - 1));
  assign tclk_tick = clock_origin_select ? slow_tick : 1'b1; // see [RULE_18] [RULE_14]

  tocc_prescaler u_clock_divider_select (
    .mclk     (mclk),
    .rst      (rst),
    .run      (run_en && !mode_cnt),
    .div_sel  (clock_divider_select),
    .tick_in  (tclk_tick),
    .tick_out (clock_divider_select_tick)
  );

  // Input edge detect; polarity 0 picks rising edges, 1 falling edges.
  always_ff @(posedge mclk) begin
    if (rst) begin
      in_q <= 1'b0;
    end else begin
      in_q <= tmr_in;
    end
  end
  assign in_edge = edge_and_level_select ? (in_q && !tmr_in)
                                         : (!in_q && tmr_in); // see [RULE_08] [RULE_19] [RULE_10]

  // Counter mode counts raw input edges with no prescaler.
  assign step = run_en && (mode_cnt ? in_edge                 // see [RULE_07] [RULE_09]
                                    : (clock_divider_select_tick && state_q != TOCC_IDLE)); // see [RULE_04] [RULE_05]
  assign hit  = step && (cnt_q == rld_q); // see [RULE_20]

  assign req    = avs_read || avs_write;
  assign wr_acc = avs_write && !ack_q;
  assign rd_acc = avs_read && !ack_q;

  // Bus handshake: one wait cycle, then the access completes.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end
  assign avs_waitrequest = !ack_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl0_q <= `TOCC_CTRL0_RESET;
      ctrl1_q <= `TOCC_CTRL1_RESET;
      rld_q   <= `TOCC_RLD_RESET;
    end else if (wr_acc) begin
      unique case (avs_address)
        `TOCC_OFS_CTRL0:  ctrl0_q     <= avs_writedata[7:0];
        `TOCC_OFS_CTRL1:  ctrl1_q     <= avs_writedata[7:0];
        `TOCC_OFS_RLD_HI: rld_q[15:8] <= avs_writedata[7:0];
        `TOCC_OFS_RLD_LO: rld_q[7:0]  <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // Sequencer for idle, triggered one-shot and free running.
  always_ff @(posedge mclk) begin
    if (rst || !run_en) begin
      state_q <= TOCC_IDLE;
    end else begin
      unique case (state_q)
        TOCC_IDLE: begin
          if (mode_cont) begin
            state_q <= TOCC_FREE;
          end else if (mode_one && in_edge) begin
            state_q <= TOCC_RUN;
          end
        end
        TOCC_RUN: begin
          if (hit) begin
            state_q <= TOCC_IDLE; // see [RULE_03]
          end
        end
        TOCC_FREE: begin
          if (!mode_cont) begin
            state_q <= TOCC_IDLE;
          end
        end
        default: state_q <= TOCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= `TOCC_CNT_START;
    end else if (hit) begin
      cnt_q <= `TOCC_CNT_START; // see [RULE_01] [RULE_06] [RULE_11]
    end else if (step) begin
      cnt_q <= cnt_q + 16'h0001;
    end else if (wr_acc && avs_address == `TOCC_OFS_CNT_HI) begin
      cnt_q[15:8] <= avs_writedata[7:0];
    end else if (wr_acc && avs_address == `TOCC_OFS_CNT_LO) begin
      cnt_q[7:0] <= avs_writedata[7:0];
    end
  end

  // Output pin: idle level is the polarity bit, pulsed in one-shot, toggled in counter mode.
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_q <= 1'b0;
    end else if (!run_en) begin
      out_q <= edge_and_level_select; // see [RULE_13] [RULE_19]
    end else if (hit && mode_cnt) begin
      out_q <= out_en ? !out_q : out_q; // see [RULE_12]
    end else if (hit && mode_one) begin
      out_q <= !edge_and_level_select; // see [RULE_02]
    end else if (mode_one && clock_divider_select_tick) begin
      out_q <= edge_and_level_select; // see [RULE_02]
    end else if (hit) begin
      out_q <= !out_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= hit; // see [RULE_16]
    end
  end

  // Sticky reload flag; a reload in the clearing cycle wins.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (hit) begin
      pend_q <= 1'b1;
    end else if (wr_acc && avs_address == `TOCC_OFS_STATUS && avs_writedata[0]) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_acc) begin
      unique case (avs_address)
        `TOCC_OFS_CTRL0:  rdata_q <= {24'h000000, ctrl0_q};
        `TOCC_OFS_CTRL1:  rdata_q <= {24'h000000, ctrl1_q};
        `TOCC_OFS_CNT_HI: rdata_q <= {24'h000000, cnt_q[15:8]};
        `TOCC_OFS_CNT_LO: rdata_q <= {24'h000000, cnt_q[7:0]};
        `TOCC_OFS_RLD_HI: rdata_q <= {24'h000000, rld_q[15:8]};
        `TOCC_OFS_RLD_LO: rdata_q <= {24'h000000, rld_q[7:0]};
        `TOCC_OFS_STATUS: rdata_q <= {27'h0000000, state_q, out_q, pend_q};
        default:          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;
  assign tmr_out      = out_q;
  assign tmr_irq      = irq_q;

  property p_reload_count;
    @(posedge mclk) disable iff (rst) hit |=> cnt_q == `TOCC_CNT_START;
  endproperty
  a_reload_count: assert property (p_reload_count) else $error("count not 0001H after reload"); // see [RULE_01]

  property p_irq_follows;
    @(posedge mclk) disable iff (rst) hit |=> tmr_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("no interrupt on reload"); // see [RULE_11]

  property p_os_idle;
    @(posedge mclk) disable iff (rst) (hit && state_q == TOCC_RUN) |=> state_q == TOCC_IDLE;
  endproperty
  a_os_idle: assert property (p_os_idle) else $error("one-shot did not idle"); // see [RULE_03]

  property p_os_pulse;
    @(posedge mclk) disable iff (rst)
      (hit && mode_one && run_en) |=> tmr_out == !edge_and_level_select;
  endproperty
  a_os_pulse: assert property (p_os_pulse) else $error("one-shot pulse level wrong"); // see [RULE_02]

  property p_cnt_toggle;
    @(posedge mclk) disable iff (rst)
      (hit && mode_cnt && out_en) |=> tmr_out != $past(tmr_out);
  endproperty
  a_cnt_toggle: assert property (p_cnt_toggle) else $error("counter output did not toggle"); // see [RULE_12]

  property p_idle_hold;
    @(posedge mclk) disable iff (rst)
      (state_q == TOCC_IDLE && !mode_cnt) |=> cnt_q == $past(cnt_q) || $past(wr_acc);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved while idle"); // see [RULE_03]

  property p_off_level;
    @(posedge mclk) disable iff (rst) !run_en |=> tmr_out == $past(edge_and_level_select);
  endproperty
  a_off_level: assert property (p_off_level) else $error("disabled level wrong"); // see [RULE_13]

  property p_cnt_edge;
    @(posedge mclk) disable iff (rst)
      (run_en && mode_cnt && in_edge && cnt_q != rld_q) |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_cnt_edge: assert property (p_cnt_edge) else $error("edge not counted"); // see [RULE_07]

  property p_div1;
    @(posedge mclk) disable iff (rst)
      (run_en && state_q == TOCC_FREE && clock_divider_select == 3'h0 && !clock_origin_select
       && cnt_q != rld_q && !wr_acc) |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one failed"); // see [RULE_17]

  c_oneshot: cover property (@(posedge mclk) disable iff (rst) hit && mode_one);
  c_counter: cover property (@(posedge mclk) disable iff (rst) hit && mode_cnt && out_en);
  c_cont:    cover property (@(posedge mclk) disable iff (rst) hit && mode_cont);
endmodule : tocc_timer

/* File: test/tocc_pin_model.sv */
// Pin-side model: drives the timer input and watches the timer output.
module tocc_pin_model (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rst,
  // Timer pins.
  output logic      tmr_in,
  input  wire logic tmr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int hi_n;
  initial tmr_in = 1'b0;
  // Each level is held five clocks so the pin never toggles too fast.
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge mclk);
      tmr_in <= ~tmr_in;
      repeat (4) @(posedge mclk);
    end
  endtask : toggle
  always @(posedge mclk) begin
    if (rst)
      hi_n <= 0;
    else if (tmr_out === 1'b1)
      hi_n <= hi_n + 1;
  end
endmodule : tocc_pin_model

/* File: test/tocc_timer_test.sv */
// Self-checking bench of the timer: register bus, three modes and pins.
`include "tocc_params.svh"
module tocc_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        tmr_in;
  logic        tmr_out;
  logic        tmr_irq;
  logic [31:0] rd;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          irq_n = 0;
  int          last = 0;
  int          gap = 0;

  tocc_timer #(.SLOW_DIV(4)) dut_u (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tmr_in(tmr_in),
    .tmr_out(tmr_out), .tmr_irq(tmr_irq));
  tocc_pin_model pin_u (.mclk(mclk), .rst(rst), .tmr_in(tmr_in), .tmr_out(tmr_out));

  always #25 mclk = ~mclk;

  // Interrupt pulses are counted and the spacing of the last two kept.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (tmr_irq === 1'b1) begin
      irq_n <= irq_n + 1;
      gap   <= cyc - last;
      last  <= cyc;
    end
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_v

  task automatic chk_n(input int got, input int exp, input string m);
    samples_checked++;
    if (got != exp) begin
      err_count++;
      $display("FAIL t=%0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask : chk_n

  // Waitrequest is stable from the falling edge up to the rising edge that samples it.
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= {24'h000000, d};
    @(negedge mclk);
    while (avs_waitrequest !== 1'b0) @(negedge mclk);
    rd = avs_readdata;
    @(posedge mclk);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk_v(rd, {24'h000000, e}, "read");
  endtask : rchk

  task automatic cfg(input logic [7:0] c0, input logic [7:0] c1, input logic [15:0] rl,
                     input logic [15:0] st);
    bus(1'b1, `TOCC_OFS_CTRL1, {1'b0, c1[6:0]});
    bus(1'b1, `TOCC_OFS_CTRL0, c0);
    bus(1'b1, `TOCC_OFS_RLD_HI, rl[15:8]);
    bus(1'b1, `TOCC_OFS_RLD_LO, rl[7:0]);
    bus(1'b1, `TOCC_OFS_CNT_HI, st[15:8]);
    bus(1'b1, `TOCC_OFS_CNT_LO, st[7:0]);
    bus(1'b1, `TOCC_OFS_CTRL1, c1);
  endtask : cfg

  task automatic wait_irq(input int n);
    for (int i = 0; i < 3000 && irq_n < n; i++) @(negedge mclk);
  endtask : wait_irq

  task automatic t_regs();
    rchk(`TOCC_OFS_CTRL0, 8'h00);
    rchk(`TOCC_OFS_RLD_HI, 8'hFF);
    bus(1'b1, 5'h1C, 8'h5A);
    rchk(5'h1C, 8'h00);
    bus(1'b1, `TOCC_OFS_RLD_LO, 8'hA5);
    rchk(`TOCC_OFS_RLD_LO, 8'hA5);
  endtask : t_regs

  task automatic t_cont(input logic [7:0] c1, input int per);
    cfg(8'h31, c1, 16'h0005, 16'h0001);
    wait_irq(irq_n + 3);
    chk_n(gap, per, "period");
  endtask : t_cont

  task automatic t_first();
    int t0;
    cfg(8'h31, 8'h80, 16'h0014, 16'h000F);
    t0 = cyc;
    wait_irq(irq_n + 1);
    chk_n(int'(last - t0 < 10), 1, "first period");
    wait_irq(irq_n + 1);
    chk_n(gap, 20, "later period");
  endtask : t_first

  task automatic t_oneshot();
    int b;
    int h;
    int t0;
    cfg(8'h3B, 8'h80, 16'h0004, 16'h0001);
    b = irq_n;
    h = pin_u.hi_n;
    repeat (40) @(negedge mclk);
    chk_n(irq_n, b, "early expiry");
    chk_v({31'h0, tmr_out}, 32'h0, "idle level");
    t0 = cyc;
    pin_u.toggle(1);
    wait_irq(b + 1);
    chk_n(int'(last - t0 >= 3 && last - t0 <= 12), 1, "time-out");
    repeat (40) @(negedge mclk);
    chk_n(pin_u.hi_n - h, 1, "pulse width");
    chk_n(irq_n, b + 1, "single expiry");
    rchk(`TOCC_OFS_CNT_LO, 8'h01);
    rchk(`TOCC_OFS_CNT_HI, 8'h00);
    pin_u.toggle(2);
    wait_irq(b + 2);
    chk_n(irq_n, b + 2, "retrigger");
  endtask : t_oneshot

  // Five toggles from low give three rising and two falling edges.
  task automatic t_counter(input logic pol, input int irqs, input logic [7:0] lo);
    int b;
    if (tmr_in === 1'b1)
      pin_u.toggle(1);
    cfg(8'h33, {1'b1, pol, 6'h23}, 16'h0003, 16'h0001);
    chk_v({31'h0, tmr_out}, {31'h0, pol}, "preset level");
    b = irq_n;
    pin_u.toggle(5);
    repeat (10) @(negedge mclk);
    chk_n(irq_n - b, irqs, "reloads");
    rchk(`TOCC_OFS_CNT_LO, lo);
    chk_v({31'h0, tmr_out}, 32'h1, "output after reload");
  endtask : t_counter

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk_v({30'h0, tmr_out, tmr_irq}, 32'h0, "reset pins");
    t_regs();
    t_cont(8'h80, 5);
    t_cont(8'h81, 10);
    t_cont(8'h83, 40);
    t_cont(8'h88, 20);
    t_first();
    t_oneshot();
    t_counter(1'b0, 1, 8'h01);
    t_counter(1'b1, 0, 8'h03);
    summarize();
  end
endmodule : tocc_timer_test
